// ===== pkg/husp_pkg.sv
package husp_pkg;
  // ----------------------------------------------------------------
  // widths and line coding
  // ----------------------------------------------------------------
  localparam int          DATA_W    = 16;
  localparam int          CNT_W     = 5;
  localparam logic [4:0]  WORD_BITS = 5'h10;
  localparam logic [4:0]  HALF_BITS = 5'h08;
  localparam logic [2:0]  STUFF_RUN = 3'h6;   // ones before a stuffed zero
  // ----------------------------------------------------------------
  // clock synthesis by phase accumulators
  // ----------------------------------------------------------------
  localparam int          ACC_W     = 16;
  localparam int          SYS_MHZ   = 100;
  localparam int          IFC_MHZ   = 30;
  localparam int          AUX_MHZ   = 48;
  localparam logic [15:0] INC_IFC   = 16'((IFC_MHZ * (2 ** ACC_W)) / SYS_MHZ);
  localparam logic [15:0] INC_AUX   = 16'((AUX_MHZ * (2 ** ACC_W)) / SYS_MHZ);
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 4;
  localparam int          REG_W     = 8;
  localparam logic [3:0]  REG_CTRL  = 4'h0;
  localparam logic [3:0]  REG_STAT  = 4'h4;
  localparam logic [3:0]  REG_MASK  = 4'h8;
  localparam int          CTRL_BYP  = 0;      // ctrl: bypass stuffing and nrzi
  localparam int          EVT_W     = 3;
  localparam int          EVT_ERR   = 0;      // receive stuff error
  localparam int          EVT_RXW   = 1;      // receive word presented
  localparam int          EVT_TXW   = 2;      // transmit word taken
  localparam int          ST_SUSP   = 3;      // status: suspend level
  localparam int          ST_STATE  = 4;      // status: operating state, 2 bits
  // ----------------------------------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------------------------------
  localparam int P_SUSP = 0, P_RST = 1, P_SEL0 = 2, P_SEL1 = 3, P_TXV = 4, P_STF = 5;
  localparam int P_DIR  = 6, P_RXA = 7, P_RXB = 8, P_DP = 9, P_DM = 10, P_DIF = 11;
  localparam int PIN_W  = 12;
  // operating state: gray along disconnect, full speed, chirp, high speed
  typedef enum logic [1:0] {
    ST_DISC  = 2'h0,
    ST_FULL  = 2'h1,
    ST_CHIRP = 2'h3,
    ST_HIGH  = 2'h2
  } husp_state_t;
  // receive phase
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_WORD = 2'h1,
    RX_DROP = 2'h3
  } husp_rxph_t;
endpackage

// ===== design/husp_top.sv
`timescale 1ns/1ps
module husp_top (
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  // control pins
  input  wire logic              RESET_I,
  input  wire logic              SUSPEND_I,
  input  wire logic              STATE_SELECT_BIT0_I,
  input  wire logic              STATE_SELECT_BIT1_I,
  input  wire logic              TX_VALID_OR_FS_OE_N_I,
  input  wire logic              STUFF_ENABLE_OR_FS_FORCE_SE0_I,
  input  wire logic              BUS_DIRECTION_SELECT_I,
  // parallel data bus
  input  wire logic [15:0]       DATA_I,
  output logic      [15:0]       DATA_O,
  output logic                   DATA_OE_N_O,
  // status pins
  output logic                   TX_READY_O,
  output logic                   RX_LAST_BYTE_O,
  output logic                   STUFF_ERROR_OR_FS_DIFF_RX_O,
  output logic                   RX_QUALIFIER_OR_DPLUS_RX_O,
  output logic                   LINE_IDLE_OR_DMINUS_RX_O,
  // clocks and power
  output logic                   INTERFACE_CLOCK_THIRTY_O,
  output logic                   CLK_OUT_FORTYEIGHT_O,
  output logic                   PULLUP_SWITCH_NODE_O,
  output logic                   LOW_POWER_O,
  // line front end
  input  wire logic              HS_RX_ACTIVE_I,
  input  wire logic              HS_RX_BIT_I,
  input  wire logic              FS_DPLUS_I,
  input  wire logic              FS_DMINUS_I,
  input  wire logic              FS_DIFF_I,
  output logic                   HS_TX_ACTIVE_O,
  output logic                   HS_TX_BIT_O,
  output logic                   FS_DRIVE_EN_O,
  output logic                   FS_SE0_O,
  // register port
  input  wire logic [3:0]        REG_ADDR_I,
  input  wire logic [7:0]        REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [7:0]        REG_RDATA_O,
  output logic                   IRQ_O
);
  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] s1;        // first synchroniser stage
    logic [11:0] s2;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] acc_ifc;
    logic [15:0] acc_aux;
    logic        clk_ifc;
    logic        clk_aux;
    logic [1:0]  rise_p;    // interface clock rise, aligned to synced pins
    logic [1:0]  rdy_p;     // ready as shown at that rise
    logic [15:0] tx_sh;
    logic [4:0]  tx_left;
    logic [2:0]  tx_ones;
    logic        tx_stf;
    logic        tx_raw;
    logic        tx_lvl;
    logic        tx_en;
    logic        tx_rdy;
    logic        rx_prev;
    logic [2:0]  rx_ones;
    logic [15:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic [1:0]  rx_ph;
    logic        pend;
    logic [15:0] pend_w;
    logic        pend_last;
    logic        pend_err;
    logic [15:0] dat;
    logic        dat_oe_n;
    logic        rx_val;
    logic        rx_last;
    logic        rx_err;
    logic        o_q;
    logic        o_e;
    logic        o_i;
    logic        fs_en;
    logic        fs_se0;
    logic        pull;
    logic        lowp;
    logic [7:0]  ctrl;
    logic [7:0]  mask;
    logic [2:0]  stat;
    logic [7:0]  rdata;
    logic        irq;
  } husp_st_t;

  localparam husp_st_t RST_VAL = '{tx_lvl: 1'b1, rx_prev: 1'b1, dat_oe_n: 1'b1, default: '0};

  husp_st_t q_ff;
  husp_st_t nxt_q;
  husp_pkg::husp_state_t st_w;
  logic        susp_w;
  logic        rst_w;
  logic        hs_w;
  logic        byp_w;
  logic        take_w;
  logic        fall_w;
  logic        dec_w;
  logic [2:0]  evt_w;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    evt_w = '0;
    susp_w = q_ff.s2[husp_pkg::P_SUSP];
    rst_w  = q_ff.s2[husp_pkg::P_RST];
    st_w   = husp_pkg::husp_state_t'(q_ff.s2[husp_pkg::P_SEL1:husp_pkg::P_SEL0]);
    hs_w   = (st_w == husp_pkg::ST_HIGH) || (st_w == husp_pkg::ST_CHIRP);
    byp_w  = q_ff.ctrl[husp_pkg::CTRL_BYP];
    // clock synthesis, frozen low in suspend
    if (susp_w) begin
      nxt_q.clk_ifc = 1'b0;
      nxt_q.clk_aux = 1'b0;
    end else begin
      nxt_q.acc_ifc = q_ff.acc_ifc + husp_pkg::INC_IFC;
      nxt_q.acc_aux = q_ff.acc_aux + husp_pkg::INC_AUX;
      nxt_q.clk_ifc = nxt_q.acc_ifc[husp_pkg::ACC_W-1];
      nxt_q.clk_aux = nxt_q.acc_aux[husp_pkg::ACC_W-1];
    end
    fall_w = q_ff.clk_ifc & ~nxt_q.clk_ifc;
    // pins launched at a rise are read once they leave the synchroniser
    nxt_q.rise_p = {q_ff.rise_p[0], nxt_q.clk_ifc & ~q_ff.clk_ifc};
    nxt_q.rdy_p  = {q_ff.rdy_p[0], q_ff.tx_rdy};
    take_w = q_ff.rise_p[1] & q_ff.rdy_p[1] & hs_w & q_ff.s2[husp_pkg::P_TXV] & ~susp_w;
    // serialiser: stuffing, shifting, nrzi
    nxt_q.tx_en = 1'b0;
    if (q_ff.tx_stf && !byp_w && q_ff.tx_ones == husp_pkg::STUFF_RUN) begin
      nxt_q.tx_raw  = 1'b0;
      nxt_q.tx_ones = '0;
      nxt_q.tx_en   = 1'b1;
    end else if (q_ff.tx_left != '0) begin
      nxt_q.tx_raw  = q_ff.tx_sh[0];
      nxt_q.tx_sh   = q_ff.tx_sh >> 1;
      nxt_q.tx_left = q_ff.tx_left - 5'h01;
      nxt_q.tx_ones = q_ff.tx_sh[0] ? q_ff.tx_ones + 3'h1 : 3'h0;
      nxt_q.tx_en   = 1'b1;
    end else if (!take_w) begin
      nxt_q.tx_ones = '0;
      nxt_q.tx_lvl  = 1'b1;
    end
    if (nxt_q.tx_en) begin
      nxt_q.tx_lvl = byp_w ? nxt_q.tx_raw : (nxt_q.tx_raw ? q_ff.tx_lvl : ~q_ff.tx_lvl);
    end
    if (take_w) begin
      nxt_q.tx_sh   = q_ff.d2;
      nxt_q.tx_left = husp_pkg::WORD_BITS;
      nxt_q.tx_stf  = q_ff.s2[husp_pkg::P_STF];
      evt_w[husp_pkg::EVT_TXW] = 1'b1;
    end
    nxt_q.tx_rdy = hs_w & ~susp_w & (nxt_q.tx_left == '0);
    // deserialiser: nrzi decode, destuff, assemble
    dec_w = byp_w ? q_ff.s2[husp_pkg::P_RXB] : (q_ff.s2[husp_pkg::P_RXB] == q_ff.rx_prev);
    if (hs_w && q_ff.s2[husp_pkg::P_RXA]) begin
      nxt_q.rx_prev = q_ff.s2[husp_pkg::P_RXB];
      if (q_ff.rx_ph != husp_pkg::RX_DROP) begin
        nxt_q.rx_ph = husp_pkg::RX_WORD;
        if (!byp_w && q_ff.rx_ones == husp_pkg::STUFF_RUN) begin
          nxt_q.rx_ones = '0;
          if (dec_w) begin
            nxt_q.pend      = 1'b1;
            nxt_q.pend_w    = q_ff.rx_sh;
            nxt_q.pend_last = 1'b1;
            nxt_q.pend_err  = 1'b1;
            nxt_q.rx_ph     = husp_pkg::RX_DROP;
            evt_w[husp_pkg::EVT_ERR] = 1'b1;
          end
        end else begin
          nxt_q.rx_sh[q_ff.rx_cnt[3:0]] = dec_w;
          nxt_q.rx_ones = dec_w ? q_ff.rx_ones + 3'h1 : 3'h0;
          nxt_q.rx_cnt  = q_ff.rx_cnt + 5'h01;
          if (nxt_q.rx_cnt == husp_pkg::WORD_BITS) begin
            nxt_q.pend      = 1'b1;
            nxt_q.pend_w    = nxt_q.rx_sh;
            nxt_q.pend_last = 1'b0;
            nxt_q.pend_err  = 1'b0;
            nxt_q.rx_cnt    = '0;
          end
        end
      end
    end else begin
      if (q_ff.rx_ph == husp_pkg::RX_WORD && q_ff.rx_cnt >= husp_pkg::HALF_BITS) begin
        nxt_q.pend      = 1'b1;
        nxt_q.pend_w    = q_ff.rx_sh;
        nxt_q.pend_last = 1'b1;
        nxt_q.pend_err  = 1'b0;
      end
      nxt_q.rx_ph   = husp_pkg::RX_IDLE;
      nxt_q.rx_cnt  = '0;
      nxt_q.rx_ones = '0;
      nxt_q.rx_prev = 1'b1;
    end
    // presentation on the interface clock fall
    if (fall_w) begin
      nxt_q.rx_val  = q_ff.pend;
      nxt_q.rx_last = q_ff.pend & q_ff.pend_last;
      nxt_q.rx_err  = q_ff.pend & q_ff.pend_err;
      if (q_ff.pend) begin
        nxt_q.dat  = q_ff.pend_w;
        nxt_q.pend = 1'b0;
        evt_w[husp_pkg::EVT_RXW] = 1'b1;
      end
    end
    nxt_q.dat_oe_n = ~(hs_w & q_ff.s2[husp_pkg::P_DIR] & ~susp_w);
    // shared output pins by state
    case (st_w)
      husp_pkg::ST_HIGH, husp_pkg::ST_CHIRP: begin
        nxt_q.o_q = nxt_q.rx_val;
        nxt_q.o_e = nxt_q.rx_err;
        nxt_q.o_i = ~q_ff.s2[husp_pkg::P_RXA];
      end
      default: begin
        nxt_q.o_q = q_ff.s2[husp_pkg::P_DP];
        nxt_q.o_e = q_ff.s2[husp_pkg::P_DIF];
        nxt_q.o_i = q_ff.s2[husp_pkg::P_DM];
      end
    endcase
    nxt_q.fs_en  = ~hs_w & ~q_ff.s2[husp_pkg::P_TXV] & ~susp_w;
    nxt_q.fs_se0 = ~hs_w & q_ff.s2[husp_pkg::P_STF];
    nxt_q.pull   = ~susp_w & ((st_w == husp_pkg::ST_FULL) || (st_w == husp_pkg::ST_CHIRP));
    nxt_q.lowp   = susp_w;
    // register port; an event in a clearing read still lands
    nxt_q.rdata = '0;
    if (REG_WR_I && REG_ADDR_I == husp_pkg::REG_CTRL) begin
      nxt_q.ctrl = REG_WDATA_I;
    end
    if (REG_WR_I && REG_ADDR_I == husp_pkg::REG_MASK) begin
      nxt_q.mask = REG_WDATA_I;
    end
    nxt_q.stat = ((REG_RD_I && REG_ADDR_I == husp_pkg::REG_STAT) ? 3'h0 : q_ff.stat) | evt_w;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        husp_pkg::REG_CTRL: nxt_q.rdata = q_ff.ctrl;
        husp_pkg::REG_MASK: nxt_q.rdata = q_ff.mask;
        husp_pkg::REG_STAT: nxt_q.rdata = {2'h0, st_w, susp_w, q_ff.stat};
        default:            nxt_q.rdata = '0;
      endcase
    end
    nxt_q.irq = |(nxt_q.stat & q_ff.mask[husp_pkg::EVT_W-1:0]);
    // reset pin clears all but the synchronisers and the low-power flag, which follows suspend
    if (rst_w) begin
      nxt_q      = RST_VAL;
      nxt_q.lowp = susp_w;
    end
    // synchronisers keep sampling through a pin reset, so its release is seen
    nxt_q.s1 = {FS_DIFF_I, FS_DMINUS_I, FS_DPLUS_I, HS_RX_BIT_I, HS_RX_ACTIVE_I, BUS_DIRECTION_SELECT_I,
                STUFF_ENABLE_OR_FS_FORCE_SE0_I, TX_VALID_OR_FS_OE_N_I, STATE_SELECT_BIT1_I,
                STATE_SELECT_BIT0_I, RESET_I, SUSPEND_I};
    nxt_q.s2 = q_ff.s1;
    nxt_q.d1 = DATA_I;
    nxt_q.d2 = q_ff.d1;
  end

  // state register
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q_ff <= RST_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign DATA_O                      = q_ff.dat;
  assign DATA_OE_N_O                 = q_ff.dat_oe_n;
  assign TX_READY_O                  = q_ff.tx_rdy;
  assign RX_LAST_BYTE_O              = q_ff.rx_last;
  assign STUFF_ERROR_OR_FS_DIFF_RX_O = q_ff.o_e;
  assign RX_QUALIFIER_OR_DPLUS_RX_O  = q_ff.o_q;
  assign LINE_IDLE_OR_DMINUS_RX_O    = q_ff.o_i;
  assign INTERFACE_CLOCK_THIRTY_O    = q_ff.clk_ifc;
  assign CLK_OUT_FORTYEIGHT_O        = q_ff.clk_aux;
  assign PULLUP_SWITCH_NODE_O        = q_ff.pull;
  assign LOW_POWER_O                 = q_ff.lowp;
  assign HS_TX_ACTIVE_O              = q_ff.tx_en;
  assign HS_TX_BIT_O                 = q_ff.tx_lvl;
  assign FS_DRIVE_EN_O               = q_ff.fs_en;
  assign FS_SE0_O                    = q_ff.fs_se0;
  assign REG_RDATA_O                 = q_ff.rdata;
  assign IRQ_O                       = q_ff.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  susp_low_power_a: assert property (susp_w |=> LOW_POWER_O)
    else $error("suspend did not reach low power");
  take_in_hs_a: assert property (take_w |-> hs_w ##1 !TX_READY_O)
    else $error("word taken outside high speed");
  fs_drive_en_a: assert property (!hs_w && !rst_w && !susp_w && !q_ff.s2[husp_pkg::P_TXV] |=> FS_DRIVE_EN_O)
    else $error("full speed driver not enabled");
  pullup_state_a: assert property (!rst_w && (st_w == husp_pkg::ST_DISC || st_w == husp_pkg::ST_HIGH) |=> !PULLUP_SWITCH_NODE_O)
    else $error("pull-up switch closed in wrong state");
  aux_clk_run_a: assert property ((!susp_w && !rst_w)[*3] ##0 $stable(q_ff.clk_aux) |=> $changed(q_ff.clk_aux))
    else $error("48 MHz clock stalled");
  ifc_clk_run_a: assert property ((!susp_w && !rst_w)[*3] ##0 $stable(q_ff.clk_ifc) |=> $changed(q_ff.clk_ifc))
    else $error("interface clock stalled");
  bus_dir_a: assert property (!rst_w && !q_ff.s2[husp_pkg::P_DIR] |=> DATA_OE_N_O)
    else $error("bus driven while not receiving");
  err_last_a: assert property ($rose(q_ff.rx_err) |-> q_ff.rx_last && q_ff.rx_val)
    else $error("stuff error without last byte flag");
  tx_stuff_a: assert property (!rst_w && !byp_w && q_ff.tx_stf && q_ff.tx_ones == husp_pkg::STUFF_RUN
                               |=> q_ff.tx_en && !q_ff.tx_raw && q_ff.tx_ones == 3'h0)
    else $error("stuffed zero missing");
  tx_nrzi_a: assert property (!rst_w && !byp_w ##1 q_ff.tx_en |-> q_ff.tx_lvl == ($past(q_ff.tx_lvl) ^ !q_ff.tx_raw))
    else $error("nrzi encoding wrong");
  tx_load_a: assert property (take_w |=> q_ff.tx_left == husp_pkg::WORD_BITS ##1 q_ff.tx_en)
    else $error("taken word not serialised");
  rx_fall_a: assert property ($rose(q_ff.rx_val) |-> $fell(q_ff.clk_ifc))
    else $error("receive valid off the clock fall");

  tx_word_c: cover property (take_w);
  rx_word_c: cover property ($rose(q_ff.rx_val) && !q_ff.rx_last);
  rx_error_c: cover property ($rose(q_ff.rx_err));
  suspend_c: cover property ($rose(LOW_POWER_O));
endmodule // husp_top

// ===== verification/husp_sie_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// engine model: presents transmit words on the parallel bus
// ----------------------------------------------------------------
module husp_sie_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // bench command
  input  wire logic        send_i,
  input  wire logic [15:0] word_i,
  // device side
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic      [15:0] data_o,
  output logic             busy_o
);
  logic ready_q;

  // hold word and valid until ready drops after the take
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      data_o     <= 16'h0000;
      ready_q    <= 1'b0;
    end else begin
      ready_q <= tx_ready_i;
      if (send_i) begin
        tx_valid_o <= 1'b1;
        data_o     <= word_i;
      end else if (tx_valid_o && ready_q && !tx_ready_i) begin
        tx_valid_o <= 1'b0;
        data_o     <= ~data_o;
      end else if (!tx_valid_o) begin
        data_o <= ~data_o;                    // released bus never keeps old value
      end
    end
  end

  assign busy_o = tx_valid_o;
endmodule // husp_sie_model

// ===== verification/tb_hs_usb_phy_sie_pin_interface.sv
`timescale 1ns/1ps
module tb_hs_usb_phy_sie_pin_interface;
  // ----------------------------------------------------------------
  // stimulus, wiring and counters
  // ----------------------------------------------------------------
  logic        clk, rst_n, rst_pin, susp, stf, dir, fs_oe_n, use_sie, send;
  logic        hs_act, hs_bit, fs_dp, fs_dm, fs_dif, wr, rd, cap, prev_lvl;
  logic        sie_valid, sie_busy, tx_pin, oe_n, rdy, last, errp, qual, idle;
  logic        clk30, clk48, pu, lp, txa, txb, fsen, fsse0, irq;
  logic [1:0]  sel;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdat, d;
  logic [15:0] word, sie_data, bus, dout;
  logic        tx_q[$];
  int          fail_count, compares, cyc;

  assign bus    = oe_n ? sie_data : dout;
  assign tx_pin = use_sie ? sie_valid : fs_oe_n;

  husp_top dut_u (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .RESET_I(rst_pin), .SUSPEND_I(susp),
    .STATE_SELECT_BIT0_I(sel[0]), .STATE_SELECT_BIT1_I(sel[1]),
    .TX_VALID_OR_FS_OE_N_I(tx_pin), .STUFF_ENABLE_OR_FS_FORCE_SE0_I(stf),
    .BUS_DIRECTION_SELECT_I(dir), .DATA_I(bus), .DATA_O(dout), .DATA_OE_N_O(oe_n),
    .TX_READY_O(rdy), .RX_LAST_BYTE_O(last), .STUFF_ERROR_OR_FS_DIFF_RX_O(errp),
    .RX_QUALIFIER_OR_DPLUS_RX_O(qual), .LINE_IDLE_OR_DMINUS_RX_O(idle),
    .INTERFACE_CLOCK_THIRTY_O(clk30), .CLK_OUT_FORTYEIGHT_O(clk48),
    .PULLUP_SWITCH_NODE_O(pu), .LOW_POWER_O(lp), .HS_RX_ACTIVE_I(hs_act),
    .HS_RX_BIT_I(hs_bit), .FS_DPLUS_I(fs_dp), .FS_DMINUS_I(fs_dm), .FS_DIFF_I(fs_dif),
    .HS_TX_ACTIVE_O(txa), .HS_TX_BIT_O(txb), .FS_DRIVE_EN_O(fsen), .FS_SE0_O(fsse0),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdat), .IRQ_O(irq)
  );

  husp_sie_model sie_u (
    .clk_i(clk), .rst_n_i(rst_n), .send_i(send), .word_i(word),
    .tx_ready_i(rdy), .tx_valid_o(sie_valid), .data_o(sie_data), .busy_o(sie_busy)
  );

  // clock generation
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // line capture with nrzi decode: same level means one
  always @(posedge clk) begin
    if (cap && txa === 1'b1) begin
      tx_q.push_back(txb === prev_lvl);
      prev_lvl = txb;
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s", $time, m);
      fail_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdat;
  endtask

  task automatic set_state(input logic [1:0] s);
    @(posedge clk);
    sel <= s;
    tick(5);
  endtask

  task automatic count_rises(input int n, output int a, output int b);
    logic p30, p48;
    a = 0;
    b = 0;
    p30 = clk30;
    p48 = clk48;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (clk30 && !p30) a++;
      if (clk48 && !p48) b++;
      p30 = clk30;
      p48 = clk48;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_clocks();
    int a, b;
    count_rises(1000, a, b);
    chk(16'(a >= 298 && a <= 302), 1, "interface clock rate");
    chk(16'(b >= 478 && b <= 482), 1, "aux clock rate");
    @(posedge clk);
    susp <= 1'b1;
    tick(6);
    chk(16'(lp), 1, "low power in suspend");
    count_rises(100, a, b);
    chk(16'(a + b), 0, "clocks stopped in suspend");
    @(posedge clk);
    susp <= 1'b0;
    tick(6);
    chk(16'(lp), 0, "low power left");
  endtask

  task automatic t_states();
    @(posedge clk);
    {fs_oe_n, stf, dir, fs_dp, fs_dm, fs_dif} <= 6'h1D;
    for (int s = 0; s < 4; s++) begin
      set_state(2'(s));
      chk(16'(pu), 16'(s % 2), "pullup switch");
      chk(16'(oe_n), 16'(s < 2), "bus direction");
      reg_rd(husp_pkg::REG_STAT, d);
      chk(16'(d[5:4]), 16'(s), "state field");
      if (s < 2)
        chk({12'h0, fsen, qual, idle, errp}, 16'h000D, "fs pin meaning");
      else
        chk({14'h0, fsen, idle}, 16'h0001, "hs pin meaning");
    end
    @(posedge clk);
    dir <= 1'b0;
    tick(5);
    chk(16'(oe_n), 1, "bus released when sending");
    @(posedge clk);
    fs_oe_n <= 1'b1;
    set_state(2'h1);
    chk({14'h0, fsen, fsse0}, 16'h0001, "fs driver off");
  endtask

  task automatic t_tx(input logic [15:0] w, input logic en, input logic [1:0] s0);
    logic e_q[$];
    int   ones;
    set_state(s0);
    @(posedge clk);
    stf     <= en;
    use_sie <= 1'b1;
    word    <= w;
    send    <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    prev_lvl = txb;
    tx_q.delete();
    cap = 1'b1;
    tick(60);
    if (s0 < 2) chk(16'(tx_q.size()), 0, "no take in fs state");
    set_state(2'h2);
    for (int i = 0; i < 300 && (sie_busy || !rdy || txa); i++) @(posedge clk);
    tick(3);
    cap  = 1'b0;
    ones = 0;
    for (int i = 0; i < 16; i++) begin
      e_q.push_back(w[i]);
      ones = w[i] ? ones + 1 : 0;
      if (en && ones == 6) begin
        e_q.push_back(1'b0);
        ones = 0;
      end
    end
    chk(16'(rdy), 1, "ready back after word");
    chk(16'(tx_q.size()), 16'(e_q.size()), "tx bit count");
    chk(16'(tx_q == e_q), 1, "tx bit stream");
  endtask

  task automatic t_rx(input logic [15:0] w, input logic er);
    logic q[$];
    int   ones;
    logic lvl;
    set_state(2'h2);
    ones = 0;
    lvl  = 1'b1;
    for (int i = 0; i < (er ? 8 : 16); i++) begin
      q.push_back(w[i]);
      ones = w[i] ? ones + 1 : 0;
      if (ones == 6) begin
        q.push_back(1'b0);
        ones = 0;
      end
    end
    if (er) repeat (7) q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge clk);
      hs_act <= 1'b1;
      lvl = q[i] ? lvl : !lvl;
      hs_bit <= lvl;
    end
    chk(16'(idle), 0, "line active");
    @(posedge clk);
    hs_act <= 1'b0;
    hs_bit <= 1'b1;
    for (int i = 0; i < 60 && qual !== 1'b1; i++) @(negedge clk);
    chk({14'h0, qual, clk30}, 16'h0002, "qualifier at clock fall");
    chk(er ? {8'h00, dout[7:0]} : dout, er ? {8'h00, w[7:0]} : w, "rx word");
    chk({14'h0, last, errp}, {14'h0, er, er}, "rx flags");
  endtask

  // pin reset and a mid-run async reset: outputs at their reset values, then back to normal
  task automatic t_pin_reset();
    set_state(2'h1);
    @(posedge clk);
    rst_pin <= 1'b1;
    tick(6);
    chk({13'h0, pu, clk30, txb}, 16'h0001, "pin reset holds outputs");
    @(posedge clk);
    rst_pin <= 1'b0;
    tick(6);
    chk(16'(pu), 1, "pin reset released");
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk({14'h0, oe_n, txb}, 16'h0003, "async reset values");
    rst_n <= 1'b1;
    tick(5);
    chk(16'(pu), 1, "async reset released");
  endtask

  // bypass: raw line bits, no nrzi, no destuffing, long runs of ones allowed
  task automatic t_bypass();
    reg_wr(husp_pkg::REG_CTRL, 8'h01);
    set_state(2'h2);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      hs_act <= 1'b1;
      hs_bit <= (i < 8) || i[0];
    end
    @(posedge clk);
    hs_act <= 1'b0;
    hs_bit <= 1'b1;
    for (int i = 0; i < 60 && qual !== 1'b1; i++) @(negedge clk);
    chk(dout, 16'hAAFF, "bypass word");
    chk({14'h0, last, errp}, 16'h0000, "bypass flags");
    reg_wr(husp_pkg::REG_CTRL, 8'h00);
  endtask

  task automatic t_irq();
    reg_wr(husp_pkg::REG_MASK, 8'h00);
    reg_rd(husp_pkg::REG_STAT, d);
    t_rx(16'h1234, 1'b0);
    chk(16'(irq), 0, "masked event");
    reg_wr(husp_pkg::REG_MASK, 8'h02);
    tick(2);
    chk(16'(irq), 1, "unmasked event");
    reg_rd(husp_pkg::REG_MASK, d);
    chk(16'(d), 16'h0002, "mask readback");
    reg_rd(husp_pkg::REG_STAT, d);
    chk({8'h00, d & 8'h32}, 16'h0022, "status word and state");
    tick(2);
    chk(16'(irq), 0, "cleared by read");
    reg_rd(4'hC, d);
    chk(16'(d), 16'h0000, "unmapped read");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, rst_pin, susp, stf, dir, fs_oe_n, use_sie, send, cap, prev_lvl} = 10'h001;
    {hs_act, hs_bit, fs_dp, fs_dm, fs_dif, wr, rd, sel, addr, wdata, word} = 'h0;
    fail_count = 0;
    compares   = 0;
    cyc        = 0;
    tick(5);
    chk({13'h0, oe_n, txb, rdy}, 16'h0006, "reset values");
    rst_n <= 1'b1;
    tick(4);
    t_clocks();
    t_states();
    t_pin_reset();
    t_tx(16'hFFFF, 1'b1, 2'h1);
    t_tx(16'hFFFF, 1'b0, 2'h2);
    t_tx(16'h7E3F, 1'b1, 2'h3);
    t_rx(16'hFC3F, 1'b0);
    t_rx(16'h00A5, 1'b1);
    t_bypass();
    t_irq();
    stop_test();
  end
endmodule // tb_hs_usb_phy_sie_pin_interface
